// *** core/mfp_params.svh ***
// constants for the multifunction pin block: offsets, fields, reset values
// Operation
// - Bidirectional pin function select in bits 7 to 4 maps 0 disabled, 1 general output, 2 interrupt, 4 PDM clock.
// - Bidirectional function code 7 powers down all converter channels and code 8 is the mic bias switch input.
// - Bidirectional codes 9 to 13 are general input, master clock, serial audio in, PDM data A and PDM data B.
// - Bidirectional drive field in bits 2 to 0 resets to 2 and selects hi-z, push-pull, low/weak-high, low only, weak-low/high, high only.
// - Output-only pin function select resets to 0 and supports disabled, general output, interrupt and PDM clock.
// - Output-only pin drive field resets to 0 and supports hi-z, push-pull, low only and high only; the code also accepts low/weak-high and weak-low/high.
// - Output-level bit 7 sets the bidirectional pin level while it is a general output.
// - Output-level bit 6 sets the output-only pin level while it is a general output.
// - Monitor bit 7 returns the sampled bidirectional pin level while it is a general input.
// - Reserved bits read as their reset values and software writes only those values.
// - The bidirectional configuration register resets to 0x22.
// - A pin used as the interrupt output asserts at the level given by the interrupt polarity.
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH
`define MFP_ADDR_BIDIR_CFG   8'h21
`define MFP_ADDR_OUT_CFG     8'h22
`define MFP_ADDR_OUT_LEVELS  8'h29
`define MFP_ADDR_IN_MONITOR  8'h2A
`define MFP_RST_BIDIR_CFG    8'h22
`define MFP_RST_OUT_CFG      8'h00
`define MFP_RST_OUT_LEVELS   8'h00
`define MFP_RST_IN_MONITOR   8'h00
`define MFP_FUNC_MSB         7
`define MFP_FUNC_LSB         4
`define MFP_DRV_MSB          2
`define MFP_DRV_LSB          0
`define MFP_BIDIR_LEVEL_BIT  7
`define MFP_OUT_LEVEL_BIT    6
`define MFP_MON_BIT          7
`endif

// *** core/mfp_pkg.sv ***
// types for the multifunction pin block
package mfp_pkg;
  typedef logic [7:0] mfp_byte_t;
  typedef enum logic [3:0] {
    MFP_FN_DISABLED  = 4'h0,
    MFP_FN_GEN_OUT   = 4'h1,
    MFP_FN_IRQ_OUT   = 4'h2,
    MFP_FN_PDM_CLK   = 4'h4,
    MFP_FN_POWERDOWN = 4'h7,
    MFP_FN_BIAS_SW   = 4'h8,
    MFP_FN_GEN_IN    = 4'h9,
    MFP_FN_MCLK_IN   = 4'hA,
    MFP_FN_SERIAL_IN = 4'hB,
    MFP_FN_PDM_DAT_A = 4'hC,
    MFP_FN_PDM_DAT_B = 4'hD
  } mfp_func_e;
  typedef enum logic [2:0] {
    MFP_DRV_HIZ       = 3'h0,
    MFP_DRV_PUSH_PULL = 3'h1,
    MFP_DRV_LOW_WEAKH = 3'h2,
    MFP_DRV_LOW_ONLY  = 3'h3,
    MFP_DRV_WEAKL_HI  = 3'h4,
    MFP_DRV_HI_ONLY   = 3'h5
  } mfp_drv_e;
endpackage

// *** core/mfp_pin_driver.sv ***
// drive-style resolver: turns a wanted level into strong/weak enables
`timescale 1ns/10ps
module mfp_pin_driver (
  input  wire logic [2:0] drive_style,
  input  wire logic       drive_active,
  input  wire logic       level,
  output logic            strong_oe,
  output logic            weak_oe,
  output logic            out_value
);
  import mfp_pkg::*;
  always_comb begin
    strong_oe = 1'b0;
    weak_oe   = 1'b0;
    out_value = level;
    if (drive_active) begin
      case (drive_style)
        MFP_DRV_PUSH_PULL: strong_oe = 1'b1;
        MFP_DRV_LOW_WEAKH: begin
          strong_oe = ~level;
          weak_oe   = level;
        end
        MFP_DRV_LOW_ONLY:  strong_oe = ~level;
        MFP_DRV_WEAKL_HI: begin
          strong_oe = level;
          weak_oe   = ~level;
        end
        MFP_DRV_HI_ONLY:   strong_oe = level;
        default: begin
          strong_oe = 1'b0;
          weak_oe   = 1'b0;
        end
      endcase
    end
  end
endmodule

// *** core/mfp_func_decode.sv ***
// function-code decoder for one pin
`timescale 1ns/10ps
module mfp_func_decode (
  input  wire logic [3:0] func_sel,
  input  wire logic       gen_level,
  input  wire logic       irq_active,
  input  wire logic       irq_polarity,
  input  wire logic       pdm_clk,
  output logic            drive_active,
  output logic            level,
  output logic            is_gen_in
);
  import mfp_pkg::*;
  always_comb begin
    drive_active = 1'b0;
    level        = 1'b0;
    is_gen_in    = 1'b0;
    case (func_sel)
      MFP_FN_GEN_OUT: begin
        drive_active = 1'b1;
        level        = gen_level;
      end
      MFP_FN_IRQ_OUT: begin
        drive_active = 1'b1;
        level        = irq_polarity ? irq_active : ~irq_active;
      end
      MFP_FN_PDM_CLK: begin
        drive_active = 1'b1;
        level        = pdm_clk;
      end
      MFP_FN_GEN_IN:  is_gen_in = 1'b1;
      default: begin
        drive_active = 1'b0;
        level        = 1'b0;
      end
    endcase
  end
endmodule

// *** core/mfp_top.sv ***
// multifunction pin configuration, levels and monitor, with register port
`timescale 1ns/10ps
`include "mfp_params.svh"
module mfp_top (
  input  wire logic             REF_CLK,
  input  wire logic             ARST_N,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire mfp_pkg::mfp_byte_t REG_ADDR,
  input  wire mfp_pkg::mfp_byte_t REG_WDATA,
  output mfp_pkg::mfp_byte_t    REG_RDATA,
  input  wire logic             IRQ_ACTIVE,
  input  wire logic             IRQ_POLARITY,
  input  wire logic             PDM_CLK_GEN,
  input  wire logic             BIDIR_PIN_I,
  output logic                  BIDIR_PIN_O,
  output logic                  BIDIR_PIN_OE,
  output logic                  BIDIR_PIN_WEAK_OE,
  output logic                  OUTPIN_O,
  output logic                  OUTPIN_OE,
  output logic                  OUTPIN_WEAK_OE,
  output logic                  POWERDOWN_ALL,
  output logic                  MIC_BIAS_SWITCH,
  output logic                  MCLK_IN,
  output logic                  SERIAL_AUDIO_IN,
  output logic                  DENSITY_MOD_DATA_A,
  output logic                  DENSITY_MOD_DATA_B
);
  import mfp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [3:0] bidir_function_sel_q,  bidir_function_sel_d;
  logic [2:0] bidir_drive_style_q,   bidir_drive_style_d;
  logic [3:0] outpin_function_sel_q, outpin_function_sel_d;
  logic [2:0] outpin_drive_style_q,  outpin_drive_style_d;
  logic       bidir_out_level_q,     bidir_out_level_d;
  logic       outpin_out_level_q,    outpin_out_level_d;
  logic       bidir_in_level_q,      bidir_in_level_d;
  mfp_byte_t  rdata_q,               rdata_d;
  mfp_byte_t  rst_bidir;
  mfp_byte_t  rst_out;

  assign rst_bidir = `MFP_RST_BIDIR_CFG;
  assign rst_out   = `MFP_RST_OUT_CFG;

  always_comb begin
    bidir_function_sel_d  = bidir_function_sel_q;
    bidir_drive_style_d   = bidir_drive_style_q;
    outpin_function_sel_d = outpin_function_sel_q;
    outpin_drive_style_d  = outpin_drive_style_q;
    bidir_out_level_d     = bidir_out_level_q;
    outpin_out_level_d    = outpin_out_level_q;
    // reserved bits are not stored; writes to them are dropped
    if (REG_WR) begin
      case (REG_ADDR)
        `MFP_ADDR_BIDIR_CFG: begin
          bidir_function_sel_d = REG_WDATA[`MFP_FUNC_MSB:`MFP_FUNC_LSB];
          bidir_drive_style_d  = REG_WDATA[`MFP_DRV_MSB:`MFP_DRV_LSB];
        end
        `MFP_ADDR_OUT_CFG: begin
          outpin_function_sel_d = REG_WDATA[`MFP_FUNC_MSB:`MFP_FUNC_LSB];
          outpin_drive_style_d  = REG_WDATA[`MFP_DRV_MSB:`MFP_DRV_LSB];
        end
        `MFP_ADDR_OUT_LEVELS: begin
          bidir_out_level_d  = REG_WDATA[`MFP_BIDIR_LEVEL_BIT];
          outpin_out_level_d = REG_WDATA[`MFP_OUT_LEVEL_BIT];
        end
        default: begin
          bidir_out_level_d = bidir_out_level_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin decode
  logic bidir_drive_active, bidir_level, bidir_is_gen_in;
  logic out_drive_active,   out_level;
  logic bidir_strong, bidir_weak, bidir_val;
  logic out_strong,   out_weak,   out_val;

  mfp_func_decode u_bidir_dec (
    .func_sel     (bidir_function_sel_q),
    .gen_level    (bidir_out_level_q),
    .irq_active   (IRQ_ACTIVE),
    .irq_polarity (IRQ_POLARITY),
    .pdm_clk      (PDM_CLK_GEN),
    .drive_active (bidir_drive_active),
    .level        (bidir_level),
    .is_gen_in    (bidir_is_gen_in)
  );

  mfp_func_decode u_out_dec (
    .func_sel     (outpin_function_sel_q),
    .gen_level    (outpin_out_level_q),
    .irq_active   (IRQ_ACTIVE),
    .irq_polarity (IRQ_POLARITY),
    .pdm_clk      (PDM_CLK_GEN),
    .drive_active (out_drive_active),
    .level        (out_level),
    .is_gen_in    ()
  );

  mfp_pin_driver u_bidir_drv (
    .drive_style  (bidir_drive_style_q),
    .drive_active (bidir_drive_active),
    .level        (bidir_level),
    .strong_oe    (bidir_strong),
    .weak_oe      (bidir_weak),
    .out_value    (bidir_val)
  );

  mfp_pin_driver u_out_drv (
    .drive_style  (outpin_drive_style_q),
    .drive_active (out_drive_active),
    .level        (out_level),
    .strong_oe    (out_strong),
    .weak_oe      (out_weak),
    .out_value    (out_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // input roles, monitor and read data
  logic pd_d, bias_d, mclk_d, serial_audio_in_d, pdma_d, pdmb_d;
  logic pd_q, bias_q, mclk_q, serial_audio_in_q, pdma_q, pdmb_q;
  logic b_o_q, b_oe_q, b_w_q, o_o_q, o_oe_q, o_w_q;

  always_comb begin
    pd_d   = (bidir_function_sel_q == MFP_FN_POWERDOWN);
    bias_d = (bidir_function_sel_q == MFP_FN_BIAS_SW) & BIDIR_PIN_I;
    mclk_d = (bidir_function_sel_q == MFP_FN_MCLK_IN) & BIDIR_PIN_I;
    serial_audio_in_d = (bidir_function_sel_q == MFP_FN_SERIAL_IN) & BIDIR_PIN_I;
    pdma_d = (bidir_function_sel_q == MFP_FN_PDM_DAT_A) & BIDIR_PIN_I;
    pdmb_d = (bidir_function_sel_q == MFP_FN_PDM_DAT_B) & BIDIR_PIN_I;
    // monitor holds its last value once the pin leaves the input role
    bidir_in_level_d = bidir_is_gen_in ? BIDIR_PIN_I : bidir_in_level_q;
    rdata_d = 8'h00;
    if (REG_RD) begin
      case (REG_ADDR)
        `MFP_ADDR_BIDIR_CFG:  rdata_d = {bidir_function_sel_q, rst_bidir[3], bidir_drive_style_q};
        `MFP_ADDR_OUT_CFG:    rdata_d = {outpin_function_sel_q, rst_out[3], outpin_drive_style_q};
        `MFP_ADDR_OUT_LEVELS: rdata_d = {bidir_out_level_q, outpin_out_level_q, 6'h00};
        `MFP_ADDR_IN_MONITOR: rdata_d = {bidir_in_level_q, 7'h00};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bidir_function_sel_q  <= 4'(`MFP_RST_BIDIR_CFG >> `MFP_FUNC_LSB);
      bidir_drive_style_q   <= 3'(`MFP_RST_BIDIR_CFG);
      outpin_function_sel_q <= 4'(`MFP_RST_OUT_CFG >> `MFP_FUNC_LSB);
      outpin_drive_style_q  <= 3'(`MFP_RST_OUT_CFG);
      bidir_out_level_q     <= 1'b0;
      outpin_out_level_q    <= 1'b0;
      bidir_in_level_q      <= 1'b0;
      rdata_q               <= 8'h00;
      pd_q   <= 1'b0;
      bias_q <= 1'b0;
      mclk_q <= 1'b0;
      serial_audio_in_q <= 1'b0;
      pdma_q <= 1'b0;
      pdmb_q <= 1'b0;
      b_o_q  <= 1'b0;
      b_oe_q <= 1'b0;
      b_w_q  <= 1'b0;
      o_o_q  <= 1'b0;
      o_oe_q <= 1'b0;
      o_w_q  <= 1'b0;
    end else begin
      bidir_function_sel_q  <= bidir_function_sel_d;
      bidir_drive_style_q   <= bidir_drive_style_d;
      outpin_function_sel_q <= outpin_function_sel_d;
      outpin_drive_style_q  <= outpin_drive_style_d;
      bidir_out_level_q     <= bidir_out_level_d;
      outpin_out_level_q    <= outpin_out_level_d;
      bidir_in_level_q      <= bidir_in_level_d;
      rdata_q               <= rdata_d;
      pd_q   <= pd_d;
      bias_q <= bias_d;
      mclk_q <= mclk_d;
      serial_audio_in_q <= serial_audio_in_d;
      pdma_q <= pdma_d;
      pdmb_q <= pdmb_d;
      // pin outputs registered: one cycle latency traded for glitch-free pads
      b_o_q  <= bidir_val;
      b_oe_q <= bidir_strong;
      b_w_q  <= bidir_weak;
      o_o_q  <= out_val;
      o_oe_q <= out_strong;
      o_w_q  <= out_weak;
    end
  end

  assign REG_RDATA          = rdata_q;
  assign BIDIR_PIN_O        = b_o_q;
  assign BIDIR_PIN_OE       = b_oe_q;
  assign BIDIR_PIN_WEAK_OE  = b_w_q;
  assign OUTPIN_O           = o_o_q;
  assign OUTPIN_OE          = o_oe_q;
  assign OUTPIN_WEAK_OE     = o_w_q;
  assign POWERDOWN_ALL      = pd_q;
  assign MIC_BIAS_SWITCH    = bias_q;
  assign MCLK_IN            = mclk_q;
  assign SERIAL_AUDIO_IN    = serial_audio_in_q;
  assign DENSITY_MOD_DATA_A = pdma_q;
  assign DENSITY_MOD_DATA_B = pdmb_q;
endmodule

// *** sim/mfp_pin_load.sv ***
// bidirectional pin load: strong, external and weak drivers plus a pull
`timescale 1ns/10ps
module mfp_pin_load #(
  parameter logic PULL_LEVEL = 1'b1
) (
  input  wire logic o,
  input  wire logic oe,
  input  wire logic weak_oe,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin
);
  // an outside strong driver beats the device's weak keeper
  always_comb begin
    if (oe)
      pin = o;
    else if (ext_en)
      pin = ext_val;
    else if (weak_oe)
      pin = o;
    else
      pin = PULL_LEVEL;
  end
endmodule

// *** sim/mfp_monitor.sv ***
// assertion checker for the multifunction pin block
`timescale 1ns/10ps
module mfp_monitor (
  input wire logic               REF_CLK,
  input wire logic               ARST_N,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire mfp_pkg::mfp_byte_t REG_ADDR,
  input wire mfp_pkg::mfp_byte_t REG_WDATA,
  input wire mfp_pkg::mfp_byte_t REG_RDATA,
  input wire logic               IRQ_ACTIVE,
  input wire logic               IRQ_POLARITY,
  input wire logic               BIDIR_PIN_O,
  input wire logic               BIDIR_PIN_OE,
  input wire logic               BIDIR_PIN_WEAK_OE,
  input wire logic               OUTPIN_O,
  input wire logic               OUTPIN_OE,
  input wire logic               POWERDOWN_ALL
);
  import mfp_pkg::*;
  mfp_byte_t bc_d, bc_q, oc_d, oc_q;
  wire       lv7 = REG_WDATA[7];
  wire       lv6 = REG_WDATA[6];
  wire       irq_lv = IRQ_ACTIVE ~^ IRQ_POLARITY;
  // shadow config bytes, only to qualify checks
  always_comb begin
    bc_d = (REG_WR && REG_ADDR == 8'h21) ? REG_WDATA : bc_q;
    oc_d = (REG_WR && REG_ADDR == 8'h22) ? REG_WDATA : oc_q;
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bc_q <= 8'h22;
      oc_q <= 8'h00;
    end else begin
      bc_q <= bc_d;
      oc_q <= oc_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    REG_RD && REG_ADDR == a ##1 1'b1;
  endsequence
  a_mon_resv_bits: assert property (s_rd(8'h2A) |-> REG_RDATA[6:0] == 7'h00)
    else $error("monitor reserved bits set");
  a_lvl_resv_bits: assert property (s_rd(8'h29) |-> REG_RDATA[5:0] == 6'h00)
    else $error("level reserved bits set");
  a_cfg_resv_bit: assert property ((s_rd(8'h21) or s_rd(8'h22)) |-> !REG_RDATA[3])
    else $error("config reserved bit set");
  a_pdown_on: assert property (s_wr(8'h21) ##0 REG_WDATA[7:4] == 4'h7 |-> ##2 POWERDOWN_ALL)
    else $error("power-down not raised");
  a_input_no_drive: assert property (s_wr(8'h21) ##0 REG_WDATA[7:4] inside {4'h0, [4'h7:4'hD]}
    |-> ##2 !BIDIR_PIN_OE && !BIDIR_PIN_WEAK_OE) else $error("input role drives pin");
  a_gen_out_drive: assert property (s_wr(8'h21) ##0 REG_WDATA == 8'h11 |-> ##2 BIDIR_PIN_OE)
    else $error("push-pull output not driven");
  a_bidir_level: assert property (s_wr(8'h29) ##1 bc_q == 8'h11 |=> BIDIR_PIN_O == $past(lv7, 2))
    else $error("bidir level mismatch");
  a_outpin_level: assert property (s_wr(8'h29) ##1 oc_q == 8'h11
    |=> OUTPIN_OE && OUTPIN_O == $past(lv6, 2)) else $error("output pin level mismatch");
  a_irq_level: assert property (bc_q == 8'h21 |=> BIDIR_PIN_OE && BIDIR_PIN_O == $past(irq_lv))
    else $error("interrupt level mismatch");
endmodule

// *** sim/tb_mfp_top.sv ***
// self-checking bench for the multifunction pin block
`timescale 1ns/10ps
module tb_mfp_top;
  import mfp_pkg::*;
  logic       ref_clk, arst_n, reg_wr, reg_rd, irq_active, irq_polarity, pdm_clk_gen, ext_en, ext_val, lv;
  logic       bp_i, bp_o, bp_oe, bp_woe, op_o, op_oe, op_woe, pd, mb, mc, sa, da, db;
  mfp_byte_t  reg_addr, reg_wdata, reg_rdata;
  int         n_fail, comparisons, cyc;
  logic [2:0] ods [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
  mfp_top mfp_top_inst (.REF_CLK(ref_clk), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .IRQ_ACTIVE(irq_active),
    .IRQ_POLARITY(irq_polarity), .PDM_CLK_GEN(pdm_clk_gen), .BIDIR_PIN_I(bp_i), .BIDIR_PIN_O(bp_o),
    .BIDIR_PIN_OE(bp_oe), .BIDIR_PIN_WEAK_OE(bp_woe), .OUTPIN_O(op_o), .OUTPIN_OE(op_oe),
    .OUTPIN_WEAK_OE(op_woe), .POWERDOWN_ALL(pd), .MIC_BIAS_SWITCH(mb), .MCLK_IN(mc),
    .SERIAL_AUDIO_IN(sa), .DENSITY_MOD_DATA_A(da), .DENSITY_MOD_DATA_B(db));
  mfp_pin_load mfp_pin_load_inst (.o(bp_o), .oe(bp_oe), .weak_oe(bp_woe), .ext_en(ext_en),
    .ext_val(ext_val), .pin(bp_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [7:0] seen, logic [7:0] exp, string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp, "read data");
  endtask
  // {strong, weak, level} wanted for a drive style; level masked when undriven
  function automatic logic [2:0] drv(logic [2:0] d, logic l);
    case (d)
      3'h1: drv = {2'b10, l};
      3'h2: drv = l ? 3'b011 : 3'b100;
      3'h3: drv = l ? 3'b000 : 3'b100;
      3'h4: drv = l ? 3'b101 : 3'b010;
      3'h5: drv = l ? 3'b101 : 3'b000;
      default: drv = 3'b000;
    endcase
  endfunction
  task automatic pins(logic [2:0] eb, logic [2:0] eo);
    @(negedge ref_clk);
    chk({5'h0, bp_oe, bp_woe, bp_o & (bp_oe | bp_woe)}, {5'h0, eb}, "bidir pin");
    chk({5'h0, op_oe, op_woe, op_o & (op_oe | op_woe)}, {5'h0, eo}, "output pin");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {arst_n, reg_wr, reg_rd, irq_active, irq_polarity, pdm_clk_gen, ext_en, ext_val, lv} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    void'($urandom(32'h21a44e04));
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    rd(8'h21, 8'h22);
    rd(8'h22, 8'h00);
    rd(8'h29, 8'h00);
    rd(8'h2A, 8'h00);
    for (int d = 0; d < 6; d++) begin
      for (int k = 0; k < 4; k++) begin
        {irq_active, irq_polarity} = 2'(k);
        lv = 1'($urandom);
        wr(8'h21, {4'h1, 1'b0, 3'(d)});
        wr(8'h22, {4'h1, 1'b0, ods[k]});
        wr(8'h29, {lv, ~lv, 6'h00});
        pins(drv(3'(d), lv), drv(ods[k], ~lv));
        rd(8'h29, {lv, ~lv, 6'h00});
        wr(8'h21, {4'h2, 1'b0, 3'(d)});
        wr(8'h22, {4'h2, 1'b0, ods[k]});
        pins(drv(3'(d), irq_active ~^ irq_polarity), drv(ods[k], irq_active ~^ irq_polarity));
        rd(8'h21, {4'h2, 1'b0, 3'(d)});
      end
    end
    wr(8'h21, 8'h41);
    wr(8'h22, 8'h41);
    for (int k = 0; k < 4; k++) begin
      pdm_clk_gen = k[0];
      pins({2'b10, k[0]}, {2'b10, k[0]});
    end
    ext_en = 1'b1;
    for (int f = 7; f < 14; f++) begin
      lv = 1'($urandom);
      ext_val = lv;
      wr(8'h21, {4'(f), 1'b0, 3'($urandom_range(5))});
      pins(3'b000, {2'b10, pdm_clk_gen});
      chk({1'b0, pd, mb, 1'b0, mc, sa, da, db},
          ((f == 7 || lv) ? 8'h40 >> (f - 7) : 8'h00) & 8'hEF, "roles");
      if (f == 9)
        rd(8'h2A, {lv, 7'h00});
    end
    wr(8'h21, 8'h01);
    pins(3'b000, {2'b10, pdm_clk_gen});
    ext_en = 1'b0;
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    rd(8'h22, 8'h41);
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    rd(8'h21, 8'h22);
    end_sim();
  end
endmodule
bind mfp_top mfp_monitor mfp_monitor_inst (.REF_CLK, .ARST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA,
  .REG_RDATA, .IRQ_ACTIVE, .IRQ_POLARITY, .BIDIR_PIN_O, .BIDIR_PIN_OE, .BIDIR_PIN_WEAK_OE, .OUTPIN_O,
  .OUTPIN_OE, .POWERDOWN_ALL);
